// file: tef_pkg.sv
// Constants and types shared by the timer event flag block
package tef_pkg;

   // Register byte offsets
   localparam logic [7:0]  TEF_OFS_IRQ_EN   = 8'h0c;
   localparam logic [7:0]  TEF_OFS_STATUS   = 8'h10;
   localparam logic [7:0]  TEF_OFS_CTRL     = 8'h20;
   localparam int          TEF_ADDR_W       = 8;

   // Field positions of the enable, status and control registers
   localparam int          TEF_BIT_UPD      = 0;
   localparam int          TEF_BIT_CH1      = 1;
   localparam int          TEF_BIT_CH2      = 2;
   localparam int          TEF_BIT_TRG      = 6;
   localparam int          TEF_BIT_OVC1     = 9;
   localparam int          TEF_BIT_OVC2     = 10;
   localparam int          TEF_BIT_SUPPRESS = 0;
   localparam int          TEF_BIT_SRCSEL   = 1;
   localparam int          TEF_NUM_CHAN     = 2;
   localparam int          TEF_REG_W        = 16;

   // Implemented bit masks and reset values
   localparam logic [15:0] TEF_EN_MASK      = 16'h0047;
   localparam logic [15:0] TEF_STS_MASK     = 16'h0647;
   localparam logic [15:0] TEF_IRQ_SRC_MASK = 16'h0047;
   localparam logic [15:0] TEF_EN_RESET     = 16'h0000;
   localparam logic [1:0]  TEF_CTRL_RESET   = 2'h0;

   // Slave mode and count alignment codes
   localparam logic [2:0]  TEF_SLAVE_GATED  = 3'h5;
   localparam logic [1:0]  TEF_ALIGN_EDGE   = 2'h0;

   // AXI responses
   localparam logic [1:0]  TEF_RESP_OKAY    = 2'h0;
   localparam logic [1:0]  TEF_RESP_SLVERR  = 2'h2;

   typedef enum logic [1:0] {
      TEF_WR_IDLE = 2'h0,
      TEF_WR_RESP = 2'h1
   } tef_wr_state_type;

   typedef enum logic [1:0] {
      TEF_RD_IDLE = 2'h0,
      TEF_RD_DATA = 2'h1
   } tef_rd_state_type;

endpackage

// file: tef_sticky_flag.sv
// One sticky status flag: hardware sets, software clears, set wins
`timescale 1ns/100ps
`default_nettype none
module tef_sticky_flag
   import tef_pkg::*;
(
   input  wire logic mclk,
   input  wire logic nrst,
   input  wire logic setEvt,
   input  wire logic clrEvt,
   output var  logic flag_ff
);

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         flag_ff <= 1'b0;
      end else if (setEvt) begin
         flag_ff <= 1'b1;
      end else if (clrEvt) begin
         flag_ff <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// file: tef_timer_flags.sv
// Timer event flags, interrupt enables and their AXI4-Lite register slave
// Contract
// - Enable bit 6 gates the trigger interrupt request.
// - Enable bit 2 gates the channel 2 interrupt request.
// - Enable bit 1 gates the channel 1 interrupt request.
// - Enable bit 0 gates the update interrupt request.
// - Unused enable and status bits always read as zero.
// - Channel 1 capture while its flag is set raises overcapture bit 9.
// - Channel 2 overcapture bit 10 behaves like the channel 1 one.
// - Trigger flag set on active edge, or either edge in gated mode.
// - Compare above reload sets channel 1 flag after counter overflow.
// - Input channel 1 flag sets on capture; capture read also clears it.
// - Channel 2 flag at bit 2 follows the channel 1 flag behaviour.
// - Update flag sets on each update event that source select lets through, until software clears it.
// - Software update request sets update flag when source select is zero.
// - Counter overflow sets update flag unless updates are suppressed.
// - Update suppress blocks update events, flag and shadow loads.
// - Source select one lets only overflow raise the update flag.
`timescale 1ns/100ps
`default_nettype none
module tef_timer_flags
   import tef_pkg::*;
(
   input  wire logic                     mclk,
   input  wire logic                     nrst,
   // AXI4-Lite slave
   input  wire logic [TEF_ADDR_W-1:0]    s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output var  logic                     s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output var  logic                     s_axi_wready,
   output var  logic [1:0]               s_axi_bresp,
   output var  logic                     s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [TEF_ADDR_W-1:0]    s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output var  logic                     s_axi_arready,
   output var  logic [31:0]              s_axi_rdata,
   output var  logic [1:0]               s_axi_rresp,
   output var  logic                     s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   // Timer core events
   input  wire logic                     counterOverflow,
   input  wire logic                     softwareUpdateRequest,
   input  wire logic                     triggerReinit,
   input  wire logic                     slaveTriggerInput,
   input  wire logic [2:0]               slaveModeSelect,
   input  wire logic                     softwareTriggerGen,
   input  wire logic [1:0]               countAlignmentSelect,
   input  wire logic [TEF_NUM_CHAN-1:0]  chanIsInput,
   input  wire logic [TEF_NUM_CHAN-1:0]  chanCompareMatch,
   input  wire logic [TEF_NUM_CHAN-1:0]  chanCompareAboveReload,
   input  wire logic [TEF_NUM_CHAN-1:0]  chanCapture,
   input  wire logic [TEF_NUM_CHAN-1:0]  chanSoftwareGen,
   input  wire logic [TEF_NUM_CHAN-1:0]  chanCaptureRegRead,
   // Results
   output var  logic                     updateEvent,
   output var  logic                     counterReinit,
   output var  logic                     timerIrq
);

   // Output flops
   logic                    awready_ff;
   logic                    wready_ff;
   logic                    bvalid_ff;
   logic [1:0]              bresp_ff;
   logic                    arready_ff;
   logic                    rvalid_ff;
   logic [31:0]             rdata_ff;
   logic [1:0]              rresp_ff;
   logic                    updateEvent_ff;
   logic                    counterReinit_ff;
   logic                    timerIrq_ff;

   // Write channel holding
   logic [TEF_ADDR_W-1:0]   awAddr_ff;
   logic                    awHeld_ff;
   logic [31:0]             wData_ff;
   logic [3:0]              wStrb_ff;
   logic                    wHeld_ff;
   tef_wr_state_type        wrState_ff;
   tef_rd_state_type        rdState_ff;

   // Register contents
   logic [TEF_REG_W-1:0]    irqEnable_ff;
   logic                    updateSuppress_ff;
   logic                    updateSourceSelect_ff;
   logic [TEF_REG_W-1:0]    statusFlags;
   logic                    trigPrev_ff;

   // Event decode
   logic                    doWrite;
   logic                    wrHitEnable;
   logic                    wrHitStatus;
   logic                    wrHitCtrl;
   logic                    trigEdge;
   logic                    trigEvent;
   logic                    centerAligned;
   logic                    updAny;
   logic                    updFlagSet;
   logic [TEF_REG_W-1:0]    setVec;
   logic [TEF_REG_W-1:0]    clrVec;
   logic [TEF_NUM_CHAN-1:0] chanSet;
   logic [TEF_NUM_CHAN-1:0] chanOvcSet;
   logic [TEF_NUM_CHAN-1:0] chanClrRead;
   logic [31:0]             rdValue;
   logic                    rdMapped;

   assign s_axi_awready = awready_ff;
   assign s_axi_wready  = wready_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;
   assign updateEvent   = updateEvent_ff;
   assign counterReinit = counterReinit_ff;
   assign timerIrq      = timerIrq_ff;

   // Write address and data may arrive in either order
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         awready_ff <= 1'b1;
         awHeld_ff  <= 1'b0;
         awAddr_ff  <= '0;
      end else if (s_axi_awvalid && awready_ff) begin
         awready_ff <= 1'b0;
         awHeld_ff  <= 1'b1;
         awAddr_ff  <= s_axi_awaddr;
      end else if (bvalid_ff && s_axi_bready) begin
         awready_ff <= 1'b1;
         awHeld_ff  <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wready_ff <= 1'b1;
         wHeld_ff  <= 1'b0;
         wData_ff  <= '0;
         wStrb_ff  <= '0;
      end else if (s_axi_wvalid && wready_ff) begin
         wready_ff <= 1'b0;
         wHeld_ff  <= 1'b1;
         wData_ff  <= s_axi_wdata;
         wStrb_ff  <= s_axi_wstrb;
      end else if (bvalid_ff && s_axi_bready) begin
         wready_ff <= 1'b1;
         wHeld_ff  <= 1'b0;
      end
   end

   assign doWrite     = awHeld_ff && wHeld_ff && (wrState_ff == TEF_WR_IDLE);
   assign wrHitEnable = doWrite && (awAddr_ff == TEF_OFS_IRQ_EN);
   assign wrHitStatus = doWrite && (awAddr_ff == TEF_OFS_STATUS);
   assign wrHitCtrl   = doWrite && (awAddr_ff == TEF_OFS_CTRL);

   // Write response; both channels stay closed until it is taken
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wrState_ff <= TEF_WR_IDLE;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= TEF_RESP_OKAY;
      end else begin
         case (wrState_ff)
            TEF_WR_IDLE: begin
               if (doWrite) begin
                  wrState_ff <= TEF_WR_RESP;
                  bvalid_ff  <= 1'b1;
                  bresp_ff   <= (wrHitEnable || wrHitStatus || wrHitCtrl) ?
                                TEF_RESP_OKAY : TEF_RESP_SLVERR;
               end
            end
            TEF_WR_RESP: begin
               if (s_axi_bready) begin
                  wrState_ff <= TEF_WR_IDLE;
                  bvalid_ff  <= 1'b0;
               end
            end
            default: begin
               wrState_ff <= TEF_WR_IDLE;
               bvalid_ff  <= 1'b0;
            end
         endcase
      end
   end

   // Enable register; only the low byte holds bits
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         irqEnable_ff <= TEF_EN_RESET;
      end else if (wrHitEnable && wStrb_ff[0]) begin
         irqEnable_ff <= {8'h00, wData_ff[7:0]} & TEF_EN_MASK;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         {updateSourceSelect_ff, updateSuppress_ff} <= TEF_CTRL_RESET;
      end else if (wrHitCtrl && wStrb_ff[0]) begin
         updateSuppress_ff     <= wData_ff[TEF_BIT_SUPPRESS];
         updateSourceSelect_ff <= wData_ff[TEF_BIT_SRCSEL];
      end
   end

   // Read channel; reads have no side effects here
   always_comb begin
      rdMapped = 1'b1;
      case (s_axi_araddr)
         TEF_OFS_IRQ_EN: rdValue = {16'h0000, irqEnable_ff & TEF_EN_MASK};
         TEF_OFS_STATUS: rdValue = {16'h0000, statusFlags & TEF_STS_MASK};
         TEF_OFS_CTRL:   rdValue = {30'h0, updateSourceSelect_ff, updateSuppress_ff};
         default: begin
            rdValue  = 32'h00000000;
            rdMapped = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rdState_ff <= TEF_RD_IDLE;
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= '0;
         rresp_ff   <= TEF_RESP_OKAY;
      end else begin
         case (rdState_ff)
            TEF_RD_IDLE: begin
               if (s_axi_arvalid) begin
                  rdState_ff <= TEF_RD_DATA;
                  arready_ff <= 1'b0;
                  rvalid_ff  <= 1'b1;
                  rdata_ff   <= rdValue;
                  rresp_ff   <= rdMapped ? TEF_RESP_OKAY : TEF_RESP_SLVERR;
               end
            end
            TEF_RD_DATA: begin
               if (s_axi_rready) begin
                  rdState_ff <= TEF_RD_IDLE;
                  arready_ff <= 1'b1;
                  rvalid_ff  <= 1'b0;
               end
            end
            default: begin
               rdState_ff <= TEF_RD_IDLE;
               arready_ff <= 1'b1;
               rvalid_ff  <= 1'b0;
            end
         endcase
      end
   end

   // Trigger edge detection
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         trigPrev_ff <= 1'b0;
      end else begin
         trigPrev_ff <= slaveTriggerInput;
      end
   end

   assign trigEdge  = (slaveModeSelect == TEF_SLAVE_GATED) ?
                      (slaveTriggerInput ^ trigPrev_ff) :
                      (slaveTriggerInput & ~trigPrev_ff);
   assign trigEvent = trigEdge || softwareTriggerGen;

   assign centerAligned = (countAlignmentSelect != TEF_ALIGN_EDGE);

   assign updAny     = !updateSuppress_ff &&
                       (counterOverflow || softwareUpdateRequest || triggerReinit);
   assign updFlagSet = !updateSuppress_ff &&
                       (counterOverflow ||
                        (!updateSourceSelect_ff && (softwareUpdateRequest || triggerReinit)));

   // Update strobe to shadow logic, reinit regardless of suppress
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         updateEvent_ff   <= 1'b0;
         counterReinit_ff <= 1'b0;
      end else begin
         updateEvent_ff   <= updAny;
         counterReinit_ff <= softwareUpdateRequest || triggerReinit;
      end
   end

   // Per-channel set and clear terms
   genvar c;
   generate
      for (c = 0; c < TEF_NUM_CHAN; c++) begin : gChan
         assign chanSet[c] = chanSoftwareGen[c] ||
                             (chanIsInput[c] && chanCapture[c]) ||
                             (!chanIsInput[c] &&
                              ((chanCompareMatch[c] && !centerAligned) ||
                               (counterOverflow && chanCompareAboveReload[c])));
         assign chanOvcSet[c] = chanIsInput[c] &&
                                (chanCapture[c] || chanSoftwareGen[c]) &&
                                statusFlags[TEF_BIT_CH1 + c];
         assign chanClrRead[c] = chanIsInput[c] && chanCaptureRegRead[c];
      end
   endgenerate

   always_comb begin
      setVec                = '0;
      setVec[TEF_BIT_UPD]   = updFlagSet;
      setVec[TEF_BIT_CH1]   = chanSet[0];
      setVec[TEF_BIT_CH2]   = chanSet[1];
      setVec[TEF_BIT_TRG]   = trigEvent;
      setVec[TEF_BIT_OVC1]  = chanOvcSet[0];
      setVec[TEF_BIT_OVC2]  = chanOvcSet[1];
   end

   always_comb begin
      clrVec = '0;
      for (int i = 0; i < TEF_REG_W; i++) begin
         clrVec[i] = wrHitStatus && wStrb_ff[i / 8] && !wData_ff[i];
      end
      clrVec[TEF_BIT_CH1] = clrVec[TEF_BIT_CH1] || chanClrRead[0];
      clrVec[TEF_BIT_CH2] = clrVec[TEF_BIT_CH2] || chanClrRead[1];
   end

   // Status flags; unused positions never get a flop
   genvar b;
   generate
      for (b = 0; b < TEF_REG_W; b++) begin : gFlag
         if (TEF_STS_MASK[b]) begin : gUsed
            tef_sticky_flag uFlag (
               .mclk    (mclk),
               .nrst    (nrst),
               .setEvt  (setVec[b]),
               .clrEvt  (clrVec[b]),
               .flag_ff (statusFlags[b])
            );
         end else begin : gUnused
            assign statusFlags[b] = 1'b0;
         end
      end
   endgenerate

   // Overcapture bits masked out of the request
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         timerIrq_ff <= 1'b0;
      end else begin
         timerIrq_ff <= |(statusFlags & irqEnable_ff & TEF_IRQ_SRC_MASK);
      end
   end

endmodule
`default_nettype wire

// file: tef_timer_flags_asserts.sv
// Port-level checker for the timer event flag block
`timescale 1ns/100ps
`default_nettype none
module tef_timer_flags_asserts
   import tef_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic        s_axi_awready,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic        s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        counterOverflow,
   input  wire logic        softwareUpdateRequest,
   input  wire logic        triggerReinit,
   input  wire logic        updateEvent,
   input  wire logic        counterReinit,
   input  wire logic        timerIrq
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   a_reinit_follows: assert property (
      (softwareUpdateRequest || triggerReinit) |=> counterReinit)
      else $error("counter reinit missing after request");
   a_reinit_cause: assert property (
      counterReinit |-> $past(softwareUpdateRequest || triggerReinit))
      else $error("counter reinit without request");
   a_update_cause: assert property (
      updateEvent |-> $past(counterOverflow || softwareUpdateRequest || triggerReinit))
      else $error("update event without source");
   a_rsvd_zero: assert property (
      s_axi_rvalid |-> (s_axi_rdata & 32'hffff_f9b8) == 32'h0000_0000)
      else $error("reserved read bits not zero");
   a_rd_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   a_rd_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   a_wr_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_wr_block: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");

   c_reinit: cover property (counterReinit);
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == TEF_RESP_SLVERR);
   c_irq: cover property ($rose(timerIrq));
endmodule

bind tef_timer_flags tef_timer_flags_asserts u_chk (.*);
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the timer event flag block
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import tef_pkg::*;
;
   localparam logic [7:0] EN = TEF_OFS_IRQ_EN;
   localparam logic [7:0] ST = TEF_OFS_STATUS;
   localparam logic [7:0] CT = TEF_OFS_CTRL;
   logic        mclk = 1'b0, nrst = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        updateEvent, counterReinit, timerIrq, updSeen, reinitSeen;
   logic        slaveTriggerInput = 1'b0;
   logic [2:0]  slaveModeSelect = 3'h0;
   logic [1:0]  countAlignmentSelect = 2'h0, chanIsInput = 2'h0, chanCompareAboveReload = 2'h0;
   // Event pulses packed so one task can fire any mix
   logic [11:0] ev = 12'h000;
   wire logic       counterOverflow       = ev[0];
   wire logic       softwareUpdateRequest = ev[1];
   wire logic       triggerReinit         = ev[2];
   wire logic       softwareTriggerGen    = ev[3];
   wire logic [1:0] chanCompareMatch      = ev[5:4];
   wire logic [1:0] chanCapture           = ev[7:6];
   wire logic [1:0] chanSoftwareGen       = ev[9:8];
   wire logic [1:0] chanCaptureRegRead    = ev[11:10];
   int          errors = 0, num_checks = 0;

   tef_timer_flags dut (.*);

   always #25 mclk = ~mclk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t value %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t flag %b expected %b", $time, got, exp);
      end
   endtask

   // Ready sampled at the falling edge, valid released after the taking edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ad, wd, ah, wh;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ad && wd)) begin
         @(negedge mclk);
         ah = s_axi_awready && !ad;
         wh = s_axi_wready && !wd;
         @(posedge mclk);
         if (ah) s_axi_awvalid <= 1'b0;
         if (wh) s_axi_wvalid <= 1'b0;
         ad = ad || ah;
         wd = wd || wh;
      end
      do @(negedge mclk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      @(posedge mclk);
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge mclk); while (!s_axi_arready);
      @(posedge mclk);
      s_axi_arvalid <= 1'b0;
      do @(negedge mclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk);
      s_axi_rready <= 1'b0;
   endtask

   task automatic wrok(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr(a, d, r);
      chk({30'h0, r}, 32'h0);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      chk({30'h0, r}, 32'h0);
      chk(d, exp);
   endtask

   task automatic irqchk(input logic exp);
      @(negedge mclk);
      chk1(timerIrq, exp);
   endtask

   // One-cycle event, then the registered outputs one cycle on
   task automatic pulse(input logic [11:0] v);
      @(posedge mclk);
      ev <= v;
      @(posedge mclk);
      ev <= 12'h000;
      @(negedge mclk);
      updSeen = updateEvent;
      reinitSeen = counterReinit;
      @(posedge mclk);
   endtask

   task automatic t_regs();
      logic [31:0] d;
      logic [1:0]  r;
      rdchk(EN, 32'h0);
      rdchk(ST, 32'h0);
      wrok(EN, 32'hffff_ffff);
      rdchk(EN, 32'h47);
      wr(8'h40, 32'h1, r);
      chk({30'h0, r}, 32'h2);
      rd(8'h40, d, r);
      chk({30'h0, r}, 32'h2);
      chk(d, 32'h0);
      wrok(EN, 32'h0);
      $display("register test done");
   endtask

   task automatic t_update();
      wrok(EN, 32'h1);
      pulse(12'h001);
      chk1(updSeen, 1'b1);
      rdchk(ST, 32'h1);
      irqchk(1'b1);
      wrok(ST, 32'hffff);
      rdchk(ST, 32'h1);
      wrok(ST, 32'h0);
      irqchk(1'b0);
      wrok(EN, 32'h0);
      pulse(12'h001);
      irqchk(1'b0);
      wrok(ST, 32'h0);
      wrok(CT, 32'h1);
      pulse(12'h001);
      chk1(updSeen, 1'b0);
      pulse(12'h002);
      chk1(reinitSeen, 1'b1);
      rdchk(ST, 32'h0);
      wrok(CT, 32'h2);
      pulse(12'h002);
      pulse(12'h004);
      rdchk(ST, 32'h0);
      pulse(12'h001);
      rdchk(ST, 32'h1);
      wrok(ST, 32'h0);
      wrok(CT, 32'h0);
      pulse(12'h002);
      rdchk(ST, 32'h1);
      wrok(ST, 32'h0);
      pulse(12'h004);
      chk1(reinitSeen, 1'b1);
      rdchk(ST, 32'h1);
      wrok(ST, 32'h0);
      $display("update test done");
   endtask

   task automatic t_chan();
      logic [31:0] b, o;
      for (int c = 0; c < 2; c++) begin
         b = 32'h2 << c;
         o = 32'h200 << c;
         wrok(EN, b);
         pulse(12'h010 << c);
         rdchk(ST, b);
         irqchk(1'b1);
         wrok(ST, 32'h0);
         countAlignmentSelect <= 2'h1;
         irqchk(1'b0);
         pulse(12'h010 << c);
         rdchk(ST, 32'h0);
         countAlignmentSelect <= 2'h0;
         chanCompareAboveReload <= b[2:1];
         pulse(12'h001);
         rdchk(ST, b | 32'h1);
         chanCompareAboveReload <= 2'h0;
         chanIsInput <= b[2:1];
         wrok(ST, 32'h0);
         pulse(12'h040 << c);
         rdchk(ST, b);
         pulse(12'h100 << c);
         rdchk(ST, b | o);
         pulse(12'h400 << c);
         rdchk(ST, o);
         irqchk(1'b0);
         // Capture and capture read in one cycle: the set must win
         pulse(12'h440 << c);
         rdchk(ST, b | o);
         wrok(ST, b);
         rdchk(ST, b);
         pulse(12'h040 << c);
         rdchk(ST, b | o);
         wrok(ST, 32'h0);
         rdchk(ST, 32'h0);
         chanIsInput <= 2'h0;
      end
      $display("channel test done");
   endtask

   task automatic t_trig();
      wrok(EN, 32'h40);
      slaveTriggerInput <= 1'b1;
      pulse(12'h000);
      rdchk(ST, 32'h40);
      irqchk(1'b1);
      wrok(ST, 32'h0);
      slaveTriggerInput <= 1'b0;
      pulse(12'h000);
      rdchk(ST, 32'h0);
      slaveModeSelect <= 3'h5;
      slaveTriggerInput <= 1'b1;
      pulse(12'h000);
      rdchk(ST, 32'h40);
      wrok(ST, 32'h0);
      slaveTriggerInput <= 1'b0;
      pulse(12'h000);
      rdchk(ST, 32'h40);
      wrok(ST, 32'h0);
      slaveModeSelect <= 3'h0;
      pulse(12'h008);
      rdchk(ST, 32'h40);
      $display("trigger test done");
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge mclk);
      nrst <= 1'b1;
      t_regs();
      t_update();
      t_chan();
      t_trig();
      summarize();
   end

   // Whole run is a few hundred cycles; the 20000-cycle limit leaves ample margin
   initial begin
      #(20000 * 50);
      errors++;
      summarize();
   end
endmodule
`default_nettype wire
